// [isf_defines.svh]
// register map, field positions and event indices of the status flag block
//----------------------------------------------------------------------
// Operation
// RULE_01: ack slot end loads nack into ack flag
// RULE_02: tx active from byte start to ack
// RULE_03: collision sets flag, software clears only
// RULE_04: general call hit, cleared at stop
// RULE_05: second long address byte match, stop clears
// RULE_06: transmit write while busy dropped, clash flag
// RULE_07: byte into full receive buffer flags overflow
// RULE_08: address match clears, data byte sets
// RULE_09: stop flag follows last start or stop
// RULE_10: bits 13 to 11 read zero always
// RULE_11: hardware flags self managed, all reset zero
// RULE_12: start mirrors stop, rw and buffer flags
//----------------------------------------------------------------------
`ifndef ISF_DEFINES_SVH
`define ISF_DEFINES_SVH
`define ISF_ADDR_W     2
`define ISF_OFS_STATUS 2'h0
`define ISF_OFS_TX     2'h1
`define ISF_OFS_RX     2'h2
`define ISF_B_ACK      15
`define ISF_B_TXACT    14
`define ISF_B_COLL     10
`define ISF_B_GCALL    9
`define ISF_B_LONG_ADDR_HIT    8
`define ISF_B_WCLASH   7
`define ISF_B_OVF      6
`define ISF_B_DATA     5
`define ISF_B_STOP     4
`define ISF_B_START    3
`define ISF_B_RW       2
`define ISF_B_RBF      1
`define ISF_B_TBF      0
`define ISF_STATUS_RST 16'h0000
`define ISF_NEV        9
`define ISF_EV_START   0
`define ISF_EV_STOP    1
`define ISF_EV_TXBEG   2
`define ISF_EV_ACKEND  3
`define ISF_EV_COLL    4
`define ISF_EV_GCALL   5
`define ISF_EV_ADDR10  6
`define ISF_EV_ADDR    7
`define ISF_EV_BYTE    8
`endif

// [isf_peer.sv]
// far-side bus peer model: pulses detector events on the link clock
`timescale 1ns/100ps
`include "isf_defines.svh"
module isf_peer
  import isf_pkg::*;
(
  input  wire logic       link_clk,
  output isf_link_in_type link_in
);
  //----------------------------------------------------------------
  // event pulses
  //----------------------------------------------------------------
  initial begin
    link_in = '0;
  end

  // one link cycle pulse; qualifiers flip once released, so stale values never pass
  task automatic ev(input int k, input logic v, input logic [7:0] b);
    isf_link_in_type x;
    x = '0;
    x.nack = v;
    x.rw_bit = v;
    x.rx_byte = b;
    case (k)
      `ISF_EV_START:  x.start_det = 1'b1;
      `ISF_EV_STOP:   x.stop_det = 1'b1;
      `ISF_EV_TXBEG:  x.tx_begin = 1'b1;
      `ISF_EV_ACKEND: x.ack_end = 1'b1;
      `ISF_EV_COLL:   x.collision = 1'b1;
      `ISF_EV_GCALL:  x.gcall_match = 1'b1;
      `ISF_EV_ADDR10: x.addr10_match = 1'b1;
      `ISF_EV_ADDR:   x.addr_match = 1'b1;
      default:        x.byte_done = 1'b1;
    endcase
    @(posedge link_clk);
    link_in <= x;
    @(posedge link_clk);
    link_in <= '{nack: ~v, rw_bit: ~v, rx_byte: ~b, default: 1'b0};
    // keep events of one kind well apart for the core side
    repeat (4) @(posedge link_clk);
  endtask : ev
endmodule : isf_peer

// [isf_pkg.sv]
// types shared by the status flag block
package isf_pkg;
  `include "isf_defines.svh"
  typedef struct packed {
    logic [`ISF_ADDR_W-1:0] addr;
    logic [15:0]            wdata;
    logic                   wr;
    logic                   rd;
  } isf_bus_req_type;
  typedef struct packed {
    logic       start_det;
    logic       stop_det;
    logic       tx_begin;
    logic       ack_end;
    logic       nack;
    logic       collision;
    logic       gcall_match;
    logic       addr10_match;
    logic       addr_match;
    logic       rw_bit;
    logic       byte_done;
    logic [7:0] rx_byte;
  } isf_link_in_type;
  typedef struct packed {
    logic ack;
    logic tx_act;
    logic coll;
    logic gcall;
    logic long_addr_hit;
    logic wclash;
    logic ovf;
    logic data;
    logic stop;
    logic start;
    logic rw;
    logic rx_buffer_full;
    logic tx_buffer_full;
  } isf_flags_type;
  typedef struct packed {
    logic [`ISF_NEV-1:0] s1;
    logic [`ISF_NEV-1:0] s2;
    logic [`ISF_NEV-1:0] s3;
    isf_flags_type       fl;
    logic [7:0]          rx_hold;
    logic [7:0]          tx_hold;
    logic [15:0]         rdata;
  } isf_core_type;
  typedef struct packed {
    logic [`ISF_NEV-1:0] tog;
    logic                nack;
    logic                rw;
    logic [7:0]          rx_byte;
    logic                pend_s1;
    logic                pend_s2;
  } isf_link_type;
endpackage : isf_pkg

// [isf_status.sv]
// status flag register of the two-wire bus module, with link side capture
`timescale 1ns/100ps
module isf_status
  import isf_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            link_clk,
  input  wire isf_bus_req_type req,
  output logic [15:0]          rdata,
  input  wire isf_link_in_type link_in,
  output logic [7:0]           tx_byte,
  output logic                 tx_ready,
  output logic [15:0]          status
);

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------

  // assemble the status word, unimplemented bits stay zero
  function automatic logic [15:0] pack_status(input isf_flags_type f);
    logic [15:0] v;
    v = `ISF_STATUS_RST;
    v[`ISF_B_ACK]    = f.ack;
    v[`ISF_B_TXACT]  = f.tx_act;
    v[`ISF_B_COLL]   = f.coll;
    v[`ISF_B_GCALL]  = f.gcall;
    v[`ISF_B_LONG_ADDR_HIT]  = f.long_addr_hit;
    v[`ISF_B_WCLASH] = f.wclash;
    v[`ISF_B_OVF]    = f.ovf;
    v[`ISF_B_DATA]   = f.data;
    v[`ISF_B_STOP]   = f.stop;
    v[`ISF_B_START]  = f.start;
    v[`ISF_B_RW]     = f.rw;
    v[`ISF_B_RBF]    = f.rx_buffer_full;
    v[`ISF_B_TBF]    = f.tx_buffer_full;
    return v;
  endfunction : pack_status

  // register access decode
  function automatic logic hit_reg(input isf_bus_req_type r,
                                   input logic [`ISF_ADDR_W-1:0] ofs,
                                   input logic strobe);
    return strobe && (r.addr == ofs);
  endfunction : hit_reg

  //--------------------------------------------------------------------
  // link domain reset release
  //--------------------------------------------------------------------

  logic lrst_s1;
  logic lrst;

  // assert at once, release on the link clock
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_s1 <= 1'b1;
      lrst    <= 1'b1;
    end else begin
      lrst_s1 <= 1'b0;
      lrst    <= lrst_s1;
    end
  end

  //--------------------------------------------------------------------
  // link domain: event toggles and captured data
  //--------------------------------------------------------------------

  isf_link_type        lk;
  isf_link_type        next_lk;
  isf_core_type        st;
  isf_core_type        next_st;
  logic [`ISF_NEV-1:0] link_ev;
  logic [`ISF_NEV-1:0] hit;
  logic                rd_status;
  logic                rd_rx;
  logic                wr_status;
  logic                wr_tx;
  logic                busy;

  // one pulse per detected bus event
  assign link_ev = {link_in.byte_done,
                    link_in.addr_match,
                    link_in.addr10_match,
                    link_in.gcall_match,
                    link_in.collision,
                    link_in.ack_end,
                    link_in.tx_begin,
                    link_in.stop_det,
                    link_in.start_det};

  // each event flips its toggle; data held beside it until next event
  always_comb begin
    next_lk = lk;
    next_lk.tog = lk.tog ^ link_ev;
    next_lk.pend_s1 = st.fl.tx_buffer_full;     // level into link domain
    next_lk.pend_s2 = lk.pend_s1;
    if (link_in.ack_end) begin
      next_lk.nack = link_in.nack;
    end
    if (link_in.addr_match) begin
      next_lk.rw = link_in.rw_bit;
    end
    if (link_in.byte_done) begin
      next_lk.rx_byte = link_in.rx_byte;
    end
  end

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  //--------------------------------------------------------------------
  // core domain: crossing, register port and flags
  //--------------------------------------------------------------------

  // event edges seen after two synchroniser stages
  assign hit = st.s2 ^ st.s3;

  assign rd_status = hit_reg(req, `ISF_OFS_STATUS, req.rd);
  assign rd_rx     = hit_reg(req, `ISF_OFS_RX, req.rd);
  assign wr_status = hit_reg(req, `ISF_OFS_STATUS, req.wr);
  assign wr_tx     = hit_reg(req, `ISF_OFS_TX, req.wr);
  assign busy      = st.fl.tx_buffer_full || st.fl.tx_act;

  // software effects first, hardware events after so a hardware update wins
  always_comb begin
    next_st = st;
    next_st.s1 = lk.tog;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rdata = 16'h0000;
    // reads: data stand one cycle later, unmapped gives zero
    if (rd_status) begin
      next_st.rdata = pack_status(st.fl);  // RULE_10
    end
    if (rd_rx) begin
      next_st.rdata = {8'h00, st.rx_hold};
      next_st.fl.rx_buffer_full = 1'b0;               // RULE_12
    end
    // writes: to status only clear-only bits react, and only to clearing; a transmit write loads the byte or sets the clash flag
    if (wr_status) begin
      if (!req.wdata[`ISF_B_COLL]) begin
        next_st.fl.coll = 1'b0;            // RULE_03
      end
      if (!req.wdata[`ISF_B_WCLASH]) begin
        next_st.fl.wclash = 1'b0;          // RULE_11
      end
      if (!req.wdata[`ISF_B_OVF]) begin
        next_st.fl.ovf = 1'b0;             // RULE_11
      end
    end
    if (wr_tx) begin
      if (busy) begin
        next_st.fl.wclash = 1'b1;          // RULE_06
      end else begin
        next_st.tx_hold = req.wdata[7:0];
        next_st.fl.tx_buffer_full = 1'b1;             // RULE_12
      end
    end
    // master transmit start takes the byte
    if (hit[`ISF_EV_TXBEG]) begin
      next_st.fl.tx_act = 1'b1;            // RULE_02
      next_st.fl.tx_buffer_full = 1'b0;
    end
    // end of acknowledge slot
    if (hit[`ISF_EV_ACKEND]) begin
      next_st.fl.ack = lk.nack;            // RULE_01
      next_st.fl.tx_act = 1'b0;            // RULE_02
    end
    if (hit[`ISF_EV_COLL]) begin
      next_st.fl.coll = 1'b1;              // RULE_03
    end
    // bus conditions
    if (hit[`ISF_EV_START]) begin
      next_st.fl.start = 1'b1;             // RULE_12
      next_st.fl.stop = 1'b0;              // RULE_09
    end
    if (hit[`ISF_EV_STOP]) begin
      next_st.fl.stop = 1'b1;              // RULE_09
      next_st.fl.start = 1'b0;
      next_st.fl.gcall = 1'b0;             // RULE_04
      next_st.fl.long_addr_hit = 1'b0;             // RULE_05
    end
    if (hit[`ISF_EV_GCALL]) begin
      next_st.fl.gcall = 1'b1;             // RULE_04
    end
    if (hit[`ISF_EV_ADDR10]) begin
      next_st.fl.long_addr_hit = 1'b1;             // RULE_05
    end
    // received byte moves to the holding register unless it is still full and not being read
    if (hit[`ISF_EV_BYTE]) begin
      next_st.fl.data = 1'b1;              // RULE_08
      if (st.fl.rx_buffer_full && !rd_rx) begin
        next_st.fl.ovf = 1'b1;             // RULE_07
      end else begin
        next_st.rx_hold = lk.rx_byte;
        next_st.fl.rx_buffer_full = 1'b1;             // RULE_12
      end
    end
    // own address match marks an address byte
    if (hit[`ISF_EV_ADDR]) begin
      next_st.fl.data = 1'b0;              // RULE_08
      next_st.fl.rw = lk.rw;               // RULE_12
    end
  end

  // all flags power up clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;                            // RULE_11
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign rdata    = st.rdata;
  assign tx_byte  = st.tx_hold;
  assign tx_ready = lk.pend_s2;
  assign status   = pack_status(st.fl);

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------

  property p_ack_load;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_ACKEND] |=> (st.fl.ack == $past(lk.nack));
  endproperty
  a_ack_load: assert property (p_ack_load) // RULE_01
    else $error("ack flag not loaded at ack end");

  property p_tx_set;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_TXBEG] && !hit[`ISF_EV_ACKEND] |=> st.fl.tx_act && !st.fl.tx_buffer_full;
  endproperty
  a_tx_set: assert property (p_tx_set) // RULE_02
    else $error("transmit active not set at start");

  property p_tx_clr;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_ACKEND] |=> !st.fl.tx_act;
  endproperty
  a_tx_clr: assert property (p_tx_clr) // RULE_02
    else $error("transmit active not cleared");

  property p_coll_sw;
    @(posedge clk) disable iff (rst)
    !st.fl.coll && !hit[`ISF_EV_COLL] |=> !st.fl.coll;
  endproperty
  a_coll_sw: assert property (p_coll_sw) // RULE_03
    else $error("collision flag set without event");

  property p_coll_keep;
    @(posedge clk) disable iff (rst)
    st.fl.coll && !wr_status |=> st.fl.coll;
  endproperty
  a_coll_keep: assert property (p_coll_keep) // RULE_03
    else $error("collision flag lost without clear");

  property p_stop_clr;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_STOP] && !hit[`ISF_EV_GCALL] && !hit[`ISF_EV_ADDR10]
      |=> !st.fl.gcall && !st.fl.long_addr_hit;
  endproperty
  a_stop_clr: assert property (p_stop_clr) // RULE_04
    else $error("address hit flags survive stop");

  property p_long_addr_hit_set;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_ADDR10] |=> st.fl.long_addr_hit ##1 (st.fl.long_addr_hit || $past(hit[`ISF_EV_STOP]));
  endproperty
  a_long_addr_hit_set: assert property (p_long_addr_hit_set) // RULE_05
    else $error("long address flag not held");

  property p_wclash;
    @(posedge clk) disable iff (rst)
    wr_tx && busy |=> st.fl.wclash && (st.tx_hold == $past(st.tx_hold));
  endproperty
  a_wclash: assert property (p_wclash) // RULE_06
    else $error("busy write not dropped");

  property p_ovf;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_BYTE] && st.fl.rx_buffer_full && !rd_rx
      |=> st.fl.ovf && (st.rx_hold == $past(st.rx_hold));
  endproperty
  a_ovf: assert property (p_ovf) // RULE_07
    else $error("overflow not flagged");

  property p_addr_flag;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_ADDR] |=> !st.fl.data && (st.fl.rw == $past(lk.rw));
  endproperty
  a_addr_flag: assert property (p_addr_flag) // RULE_08
    else $error("address match flags wrong");

  property p_stop_seen;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_STOP] |=> st.fl.stop && !st.fl.start;
  endproperty
  a_stop_seen: assert property (p_stop_seen) // RULE_09
    else $error("stop flag not updated");

  property p_unimpl;
    @(posedge clk) disable iff (rst)
    rd_status |=> (rdata[13:11] == 3'h0) && (rdata == $past(status));
  endproperty
  a_unimpl: assert property (p_unimpl) // RULE_10
    else $error("status read wrong");

  property p_rbf_load;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_BYTE] && !st.fl.rx_buffer_full |=> st.fl.rx_buffer_full && (st.rx_hold == $past(lk.rx_byte));
  endproperty
  a_rbf_load: assert property (p_rbf_load) // RULE_12
    else $error("receive byte not loaded");

  property p_gcall_set;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_GCALL] |=> st.fl.gcall;
  endproperty
  a_gcall_set: assert property (p_gcall_set) // RULE_04
    else $error("general call flag not set");

  property p_data_set;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_BYTE] && !hit[`ISF_EV_ADDR] |=> st.fl.data;
  endproperty
  a_data_set: assert property (p_data_set) // RULE_08
    else $error("data flag not set by byte");

  property p_start_seen;
    @(posedge clk) disable iff (rst)
    hit[`ISF_EV_START] && !hit[`ISF_EV_STOP] |=> st.fl.start && !st.fl.stop;
  endproperty
  a_start_seen: assert property (p_start_seen) // RULE_09
    else $error("stop flag not cleared by start");

  property p_tbf_load;
    @(posedge clk) disable iff (rst)
    wr_tx && !busy && !hit[`ISF_EV_TXBEG]
      |=> st.fl.tx_buffer_full && (tx_byte == $past(req.wdata[7:0]));
  endproperty
  a_tbf_load: assert property (p_tbf_load) // RULE_12
    else $error("transmit byte not taken");

endmodule : isf_status

// [isf_status_tb.sv]
// self-checking testbench of the status flag block
`timescale 1ns/100ps
`include "isf_defines.svh"
module isf_status_tb
  import isf_pkg::*;
;
  logic            clk;
  logic            rst;
  logic            link_clk;
  isf_bus_req_type req;
  logic [15:0]     rdata;
  isf_link_in_type link_in;
  logic [7:0]      tx_byte;
  logic            tx_ready;
  logic [15:0]     status;
  int              failures;
  int              total_checks;
  int              i;

  isf_status dut (.clk(clk), .rst(rst), .link_clk(link_clk), .req(req), .rdata(rdata),
    .link_in(link_in), .tx_byte(tx_byte), .tx_ready(tx_ready), .status(status));
  isf_peer peer (.link_clk(link_clk), .link_in(link_in));

  //----------------------------------------------------------------
  // clocks and watchdog
  //----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // link clock, phase unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  initial begin
    #100000;
    failures++;
    $display("BAD watchdog expected done seen timeout");
    final_report();
  end

  //----------------------------------------------------------------
  // access tasks
  //----------------------------------------------------------------
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic fl(input string n, input int b, input logic e);
    check(n, {15'h0000, e}, {15'h0000, status[b]});
  endtask : fl
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(n, e, rdata);
  endtask : rd
  task automatic ev(input int k, input logic v, input logic [7:0] b);
    peer.ev(k, v, b);
    repeat (2) @(posedge clk);
    #1;
  endtask : ev
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  //----------------------------------------------------------------
  // test sequence
  //----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = '0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    #1;
    check("status reset", 16'h0000, status);
    rd(`ISF_OFS_STATUS, 16'h0000, "status read");
    rd(2'h3, 16'h0000, "unmapped read");
    // transmit byte load, a write while busy, then master transmit
    wr(`ISF_OFS_TX, 16'h005a);
    check("tx byte", 16'h005a, {8'h00, tx_byte});
    fl("tx full", `ISF_B_TBF, 1'b1);
    for (i = 0; i < 20 && tx_ready !== 1'b1; i++) @(posedge clk);
    check("tx ready", 16'h0001, {15'h0000, tx_ready});
    wr(`ISF_OFS_TX, 16'h00a5);
    fl("write clash", `ISF_B_WCLASH, 1'b1);
    check("tx kept", 16'h005a, {8'h00, tx_byte});
    ev(`ISF_EV_TXBEG, 1'b0, 8'h00);
    fl("tx active", `ISF_B_TXACT, 1'b1);
    fl("tx taken", `ISF_B_TBF, 1'b0);
    ev(`ISF_EV_ACKEND, 1'b1, 8'h00);
    fl("ack nack", `ISF_B_ACK, 1'b1);
    fl("tx ended", `ISF_B_TXACT, 1'b0);
    ev(`ISF_EV_ACKEND, 1'b0, 8'h00);
    fl("ack ack", `ISF_B_ACK, 1'b0);
    // collision flag is clear-only
    ev(`ISF_EV_COLL, 1'b0, 8'h00);
    fl("collision", `ISF_B_COLL, 1'b1);
    wr(`ISF_OFS_STATUS, 16'hffff);
    fl("collision kept", `ISF_B_COLL, 1'b1);
    check("unused bits", 16'h0000, status & 16'h3800);
    wr(`ISF_OFS_STATUS, 16'h0000);
    fl("collision cleared", `ISF_B_COLL, 1'b0);
    fl("clash cleared", `ISF_B_WCLASH, 1'b0);
    wr(`ISF_OFS_STATUS, 16'hffff);
    fl("collision not set", `ISF_B_COLL, 1'b0);
    rd(`ISF_OFS_STATUS, 16'h0000, "status word");
    // address hits, start and stop
    ev(`ISF_EV_GCALL, 1'b0, 8'h00);
    fl("general call", `ISF_B_GCALL, 1'b1);
    ev(`ISF_EV_ADDR10, 1'b0, 8'h00);
    fl("long address", `ISF_B_LONG_ADDR_HIT, 1'b1);
    ev(`ISF_EV_START, 1'b0, 8'h00);
    fl("start seen", `ISF_B_START, 1'b1);
    fl("stop not last", `ISF_B_STOP, 1'b0);
    ev(`ISF_EV_STOP, 1'b0, 8'h00);
    fl("general call end", `ISF_B_GCALL, 1'b0);
    fl("long address end", `ISF_B_LONG_ADDR_HIT, 1'b0);
    fl("stop last", `ISF_B_STOP, 1'b1);
    fl("start cleared", `ISF_B_START, 1'b0);
    // slave receive with an overflow
    ev(`ISF_EV_ADDR, 1'b1, 8'h00);
    fl("address byte", `ISF_B_DATA, 1'b0);
    fl("read dir", `ISF_B_RW, 1'b1);
    ev(`ISF_EV_BYTE, 1'b0, 8'h3c);
    fl("data byte", `ISF_B_DATA, 1'b1);
    fl("rx full", `ISF_B_RBF, 1'b1);
    ev(`ISF_EV_BYTE, 1'b0, 8'hc3);
    fl("overflow", `ISF_B_OVF, 1'b1);
    rd(`ISF_OFS_STATUS, 16'h0076, "status busy word");
    rd(`ISF_OFS_RX, 16'h003c, "rx byte");
    fl("rx emptied", `ISF_B_RBF, 1'b0);
    wr(`ISF_OFS_STATUS, 16'h0000);
    fl("overflow cleared", `ISF_B_OVF, 1'b0);
    final_report();
  end
endmodule : isf_status_tb
